// [dma_master_ctl.sv]
/*
  master dma controller register set: status, command, software
  request, single mask, per-channel mode, byte pointer and master
  disable, behind an 8-bit i/o port bus.
  assumes io strobes are one-cycle pulses on clk_in, and that the
  transfer engine supplies terminal count, grant and temporary data
  on the same clock.
*/
module dma_master_ctl
  import dma_master_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  // i/o port bus
  input  wire logic [15:0]       io_addr_in,
  input  wire logic [7:0]        io_wdata_in,
  input  wire logic              io_wr_in,
  input  wire logic              io_rd_in,
  output logic      [7:0]        io_rdata_out,
  output logic                   io_rvalid_out,
  // request pins, channels 4 to 7 on bits 0 to 3
  input  wire logic [3:0]        transfer_request_line_in,
  output logic      [3:0]        transfer_grant_out,
  // transfer engine
  input  wire logic [3:0]        tc_event_in,
  input  wire logic [3:0]        grant_in,
  input  wire logic              temp_load_in,
  input  wire logic [7:0]        temp_data_in,
  output logic      [3:0]        service_request_out,
  output cmd_fields_t            cmd_out,
  output mode_t     [3:0]        mode_out,
  output logic      [3:0]        mode_invalid_out,
  output logic                   byte_high_out
);

  ctl_state_t  st;
  ctl_state_t  next_st;
  logic [3:0]  hw_level;
  logic [3:0]  pending;
  logic [7:0]  status_value;
  logic [1:0]  sel;
  logic        set_val;
  logic        wr_status;
  logic        rd_status;
  logic        word_access;
  logic        master_off;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] chan_onehot(input logic [1:0] code);
    chan_onehot = 4'h1 << code;
  endfunction

  function automatic logic [3:0] set_or_clear(input logic [3:0] cur,
                                              input logic [1:0] code,
                                              input logic       val);
    logic [3:0] hot;
    hot          = chan_onehot(code);
    set_or_clear = val ? (cur | hot) : (cur & ~hot);
  endfunction

  function automatic logic hit(input logic [15:0] port);
    hit = (io_addr_in == port);
  endfunction

  // ---------------------------------------------------------------
  // request pins
  // ---------------------------------------------------------------
  req_conditioner u_req (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .line_in       (transfer_request_line_in),
    .active_low_in (st.cmd.req_polarity),
    .level_out     (hw_level)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign sel         = io_wdata_in[SEL_MSB:SEL_LSB];
  assign set_val     = io_wdata_in[SET_BIT];
  assign wr_status   = io_wr_in && hit(PORT_STATUS_CMD);
  assign rd_status   = io_rd_in && hit(PORT_STATUS_CMD);
  assign master_off  = io_wr_in && hit(PORT_TEMP_DIS);
  assign word_access = (io_wr_in || io_rd_in)
                     && (io_addr_in >= PORT_WORD_FIRST)
                     && (io_addr_in <= PORT_WORD_LAST);

  assign pending = hw_level | st.sw_req;
  // cascade slot reads zero in both halves
  assign status_value = {pending[3:1], 1'b0, st.done[3:1], 1'b0};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    next_st.grant  = st.cmd.ack_polarity ? grant_in : ~grant_in;
    if (temp_load_in) begin
      next_st.temp = temp_data_in;
    end
    if (io_rd_in) begin
      next_st.rvalid = 1'b1;
      if (rd_status) begin
        next_st.rdata = status_value;
        next_st.done  = FLAG_RESET;
      end else if (hit(PORT_TEMP_DIS)) begin
        next_st.rdata = st.temp;
      end else begin
        next_st.rdata = DATA_RESET;
      end
    end
    // a terminal count in the read cycle survives the clear
    next_st.done   = next_st.done | (tc_event_in & ~CASCADE_CH);
    next_st.sw_req = st.sw_req & ~tc_event_in;
    if (word_access) begin
      next_st.byte_high = ~st.byte_high;
    end
    if (io_wr_in) begin
      case (io_addr_in)
        PORT_STATUS_CMD: begin
          next_st.cmd = cmd_fields_t'(io_wdata_in);
        end
        PORT_REQUEST: begin
          next_st.sw_req = set_or_clear(st.sw_req, sel, set_val);
        end
        PORT_MASK: begin
          next_st.mask = set_or_clear(st.mask, sel, set_val);
        end
        PORT_MODE: begin
          next_st.mode[sel] = mode_t'(io_wdata_in[MODE_MSB:MODE_LSB]);
        end
        PORT_PTR_CLEAR: begin
          next_st.byte_high = 1'b0;
        end
        default: begin
          next_st.cmd = st.cmd;
        end
      endcase
    end
    // master disable beats everything, including a same-cycle count
    if (master_off) begin
      next_st.cmd       = cmd_fields_t'(CMD_RESET);
      next_st.mask      = MASK_RESET;
      next_st.done      = FLAG_RESET;
      next_st.sw_req    = FLAG_RESET;
      next_st.temp      = DATA_RESET;
      next_st.byte_high = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st           <= '0;
      st.cmd       <= cmd_fields_t'(CMD_RESET);
      st.mask      <= MASK_RESET;
      st.grant     <= MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // masked or disabled channels never reach the arbiter
  assign service_request_out = pending & ~st.mask
                             & {CHAN_COUNT{~st.cmd.controller_off}};

  // fields whose enabling bit is clear are forced to their quiet value
  always_comb begin
    cmd_out                         = st.cmd;
    cmd_out.chan4_addr_freeze       = st.cmd.chan4_addr_freeze
                                    & st.cmd.mem_to_mem_enable;
    cmd_out.compressed_cycle_select = st.cmd.compressed_cycle_select
                                    & st.cmd.chan4_addr_freeze;
    cmd_out.write_stretch_select    = st.cmd.write_stretch_select
                                    & st.cmd.compressed_cycle_select;
  end

  // the kind field is meaningless in cascade, so it never flags there
  always_comb begin
    for (int i = 0; i < CHAN_COUNT; i++) begin
      mode_out[i]         = st.mode[i];
      mode_invalid_out[i] = (st.mode[i].transfer_kind == KIND_BAD)
                          && (st.mode[i].service_type != SVC_CASCADE);
    end
  end

  assign io_rdata_out       = st.rdata;
  assign io_rvalid_out      = st.rvalid;
  assign transfer_grant_out = st.grant;
  assign byte_high_out      = st.byte_high;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_done_set: assert property (
    (tc_event_in[1] && !master_off) |=> st.done[1])
    else $error("done flag not set by terminal count");

  a_status_clear: assert property (
    (rd_status && !master_off && tc_event_in == 4'h0) |=> (st.done == FLAG_RESET))
    else $error("status read left done flags set");

  a_pending_read: assert property (
    rd_status |=> (io_rdata_out[7:5] == $past(pending[3:1])) && io_rvalid_out)
    else $error("pending bits wrong on status read");

  a_cascade_bits: assert property (
    rd_status |=> (io_rdata_out[4] == 1'b0) && (io_rdata_out[0] == 1'b0))
    else $error("cascade status bits not zero");

  a_disable_clear: assert property (
    master_off |=> (st.cmd == cmd_fields_t'(CMD_RESET)) && (st.mask == MASK_RESET)
                   && !byte_high_out && (st.sw_req == FLAG_RESET))
    else $error("master disable did not clear controller");

  a_off_gate: assert property (
    st.cmd.controller_off |-> (service_request_out == 4'h0))
    else $error("request passed while controller disabled");

  a_cmd_load: assert property (
    wr_status |=> (cmd_out.rotating_order_select == $past(io_wdata_in[4]))
                  && (st.cmd.controller_off == $past(io_wdata_in[2])))
    else $error("command write not taken");

  a_hold_ignore: assert property (
    !st.cmd.mem_to_mem_enable |-> !cmd_out.chan4_addr_freeze)
    else $error("address hold active without memory to memory");

  a_request_bit: assert property (
    (io_wr_in && hit(PORT_REQUEST) && tc_event_in == 4'h0)
      |=> (st.sw_req[$past(sel)] == $past(set_val)))
    else $error("software request bit not updated");

  a_mask_bit: assert property (
    (io_wr_in && hit(PORT_MASK)) |=> (st.mask[$past(sel)] == $past(set_val)))
    else $error("mask bit not updated");

  a_mode_load: assert property (
    (io_wr_in && hit(PORT_MODE))
      |=> (st.mode[$past(sel)] == $past(io_wdata_in[MODE_MSB:MODE_LSB])))
    else $error("mode not loaded into selected channel");

  a_ptr_clear: assert property (
    (io_wr_in && hit(PORT_PTR_CLEAR)) |=> !byte_high_out)
    else $error("byte pointer not cleared");

  a_ptr_toggle: assert property (
    (word_access && !master_off) |=> (byte_high_out != $past(byte_high_out)))
    else $error("byte pointer did not toggle");

  a_ptr_hold: assert property (
    (!word_access && !master_off && !(io_wr_in && hit(PORT_PTR_CLEAR)))
      |=> $stable(byte_high_out))
    else $error("byte pointer moved without an access");

  // ---------------------------------------------------------------
  // checks: pins, gating and side effects
  // ---------------------------------------------------------------
  a_grant_sense: assert property (
    1'b1 |=> (transfer_grant_out == ($past(st.cmd.ack_polarity)
                                     ? $past(grant_in) : ~$past(grant_in))))
    else $error("grant sense does not follow command bit 7");

  // three flops from pin to level; skip the cycles the flops spend refilling
  a_level_sense: assert property (
    1'b1 ##3 1'b1 |-> (hw_level == ($past(transfer_request_line_in, 3)
                                    ^ {CHAN_COUNT{$past(st.cmd.req_polarity)}})))
    else $error("request level does not follow command bit 6");

  a_compress_gate: assert property (
    !st.cmd.chan4_addr_freeze |-> !cmd_out.compressed_cycle_select)
    else $error("compressed timing active without bit 1");

  a_stretch_gate: assert property (
    !st.cmd.compressed_cycle_select |-> !cmd_out.write_stretch_select)
    else $error("extended write active without bit 3");

  a_disable_gate: assert property (
    master_off |=> (service_request_out == 4'h0))
    else $error("request passed after master disable");

  a_temp_clear: assert property (
    master_off |=> (st.temp == DATA_RESET) && (st.done == FLAG_RESET))
    else $error("master disable left temp or done set");

  a_mode_keep: assert property (
    master_off |=> (st.mode == $past(st.mode)))
    else $error("master disable changed a mode");

  a_cmd_keep: assert property (
    (rd_status && !io_wr_in) |=> (st.cmd == $past(st.cmd)))
    else $error("status read changed the command");

  a_pending_keep: assert property (
    (rd_status && !io_wr_in && (tc_event_in == 4'h0))
      |=> (st.sw_req == $past(st.sw_req)))
    else $error("status read cleared a pending request");

  a_cascade_done: assert property (
    st.done[0] == 1'b0)
    else $error("cascade done flag set");

  a_cascade_flag: assert property (
    (st.mode[3].service_type == SVC_CASCADE) |-> !mode_invalid_out[3])
    else $error("kind flagged invalid in cascade");

  a_kind_flag: assert property (
    ((st.mode[0].transfer_kind == KIND_BAD)
      && (st.mode[0].service_type != SVC_CASCADE))
      |-> mode_invalid_out[0])
    else $error("invalid kind not flagged");

  a_read_answer: assert property (
    io_rd_in |=> io_rvalid_out)
    else $error("read not answered");

  a_temp_read: assert property (
    (io_rd_in && hit(PORT_TEMP_DIS)) |=> (io_rdata_out == $past(st.temp)))
    else $error("temporary register read wrong");

  a_mask_block: assert property (
    ((st.mask | {CHAN_COUNT{st.cmd.controller_off}}) & service_request_out)
      == 4'h0)
    else $error("masked channel requested service");

  a_tc_drop: assert property (
    (tc_event_in[2] && !(io_wr_in && hit(PORT_REQUEST))) |=> !st.sw_req[2])
    else $error("software request kept after terminal count");

endmodule

// [dma_master_pkg.sv]
/*
  constants, field layouts and state types for the master dma control
  register set (channels 4 to 7).
  assumes an 8-bit i/o port bus and a transfer engine on the same clock.
*/
//
// Function
// - set a channel's done flag in status bits 1-3 at terminal count
// - reading status clears the four done flags, not the pending bits
// - status bits 7, 6, 5 show pending requests of channels 7, 6, 5
// - channel 4 cascades the slave; status bits 4 and 0 carry nothing
// - command register cleared by hardware reset and by a write to DAh
// - command bit 2 set disables the controller
// - bit 7 sets grant polarity, bit 6 sets request line polarity
// - command bit 4 selects rotating (1) or fixed (0) priority
// - bit 3 compressed timing needs bit 1; bit 5 extended write needs bit 3
// - bit 0 enables memory to memory; bit 1 address hold needs bit 0
// - request port write sets or clears the chosen channel's request bit
// - mask port write sets or clears one mask; masked channel ignores requests
// - hardware reset sets every mask bit
// - a separate 6-bit mode per channel, loaded by the mode port write
// - mode bits 7-6 select demand, single, block or cascade service
// - mode bit 5 selects decrement, bit 4 enables auto reload
// - mode bits 3-2 select verify, write, read; 11 invalid unless cascade
// - any write to D8h clears the byte pointer, which is not readable
// - any write to DAh acts as a master reset of the controller
// - status read and command write share port D0h
package dma_master_pkg;

  // ---------------------------------------------------------------
  // port map
  // ---------------------------------------------------------------
  localparam logic [15:0] PORT_STATUS_CMD = 16'h00d0;
  localparam logic [15:0] PORT_REQUEST    = 16'h00d2;
  localparam logic [15:0] PORT_MASK       = 16'h00d4;
  localparam logic [15:0] PORT_MODE       = 16'h00d6;
  localparam logic [15:0] PORT_PTR_CLEAR  = 16'h00d8;
  localparam logic [15:0] PORT_TEMP_DIS   = 16'h00da;
  localparam logic [15:0] PORT_WORD_FIRST = 16'h00c0;
  localparam logic [15:0] PORT_WORD_LAST  = 16'h00ce;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          CHAN_COUNT  = 4;
  localparam int          SEL_LSB     = 0;
  localparam int          SEL_MSB     = 1;
  localparam int          SET_BIT     = 2;
  localparam int          MODE_LSB    = 2;
  localparam int          MODE_MSB    = 7;
  localparam logic [3:0]  CASCADE_CH  = 4'h1;
  localparam logic [7:0]  CMD_RESET   = 8'h00;
  localparam logic [3:0]  MASK_RESET  = 4'hf;
  localparam logic [3:0]  FLAG_RESET  = 4'h0;
  localparam logic [7:0]  DATA_RESET  = 8'h00;
  localparam logic [1:0]  KIND_BAD    = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SVC_DEMAND  = 2'h0,
    SVC_SINGLE  = 2'h1,
    SVC_BLOCK   = 2'h2,
    SVC_CASCADE = 2'h3
  } service_t;

  // bit order matches the command byte, bit 7 first
  typedef struct packed {
    logic ack_polarity;
    logic req_polarity;
    logic write_stretch_select;
    logic rotating_order_select;
    logic compressed_cycle_select;
    logic controller_off;
    logic chan4_addr_freeze;
    logic mem_to_mem_enable;
  } cmd_fields_t;

  // mode byte bits 7-2
  typedef struct packed {
    service_t   service_type;
    logic       address_direction;
    logic       auto_reload_enable;
    logic [1:0] transfer_kind;
  } mode_t;

  typedef struct packed {
    cmd_fields_t          cmd;
    logic [3:0]           done;
    logic [3:0]           sw_req;
    logic [3:0]           mask;
    mode_t [3:0]          mode;
    logic                 byte_high;
    logic [7:0]           temp;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic [3:0]           grant;
  } ctl_state_t;

  typedef struct packed {
    logic [3:0] stage1;
    logic [3:0] stage2;
    logic [3:0] level;
  } sync_state_t;

endpackage

// [req_conditioner.sv]
/*
  two-flop synchroniser for the request pins, then polarity correction.
  assumes the pins are asynchronous to clk_in.
*/
module req_conditioner
  import dma_master_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // pins and polarity
  input  wire logic [3:0] line_in,
  input  wire logic       active_low_in,
  // conditioned level, active high
  output logic      [3:0] level_out
);

  sync_state_t st;
  sync_state_t next_st;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // stage1 feeds stage2 only; polarity is applied after the second flop
  always_comb begin
    next_st        = st;
    next_st.stage1 = line_in;
    next_st.stage2 = st.stage1;
    next_st.level  = st.stage2 ^ {CHAN_COUNT{active_low_in}};
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.level;

endmodule

// [periph_model.sv]
/*
  far side of the master dma register set: request pins of the peripherals
  and the strobes of the transfer engine (terminal count, temporary data).
  assumes the bench commands it right after a rising edge of clk_in.
*/
module periph_model
  import dma_master_pkg::*;
(
  // clock
  input  wire logic       clk_in,
  // commands from the bench
  input  wire logic [3:0] want_in,
  input  wire logic       active_low_in,
  input  wire logic [3:0] tc_fire_in,
  input  wire logic       temp_fire_in,
  input  wire logic [7:0] temp_val_in,
  // pins and engine strobes toward the block
  output logic      [3:0] line_out,
  output logic      [3:0] tc_out,
  output logic            temp_load_out,
  output logic      [7:0] temp_data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // pins and engine pulses
  // ----------------------------------------
  logic [3:0] tc_prev   = 4'h0;
  logic       temp_prev = 1'b0;

  // pin level follows the sense the bench selects on active_low_in
  assign line_out = want_in ^ {4{active_low_in}};
  assign temp_data_out = temp_val_in;

  // one pulse per request, however long the bench holds it
  always @(posedge clk_in) begin
    tc_out <= tc_fire_in & ~tc_prev;
    tc_prev <= tc_fire_in;
    temp_load_out <= temp_fire_in & ~temp_prev;
    temp_prev <= temp_fire_in;
  end
endmodule

// [tb_top.sv]
/*
  self-checking bench for the master dma register set.
  assumes io strobes are one-cycle pulses and pins settle in status
  within five edges.
*/
module tb_top
  import dma_master_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [15:0] io_addr_in = 16'h0000;
  logic [7:0]  io_wdata_in = 8'h00;
  logic        io_wr_in = 1'b0;
  logic        io_rd_in = 1'b0;
  logic [3:0]  grant_in = 4'h0;
  logic [3:0]  want = 4'h0;
  logic [3:0]  tc_fire = 4'h0;
  logic        active_low = 1'b0;
  logic        temp_fire = 1'b0;
  logic [7:0]  temp_val = 8'h00;
  logic [7:0]  io_rdata_out;
  logic        io_rvalid_out;
  logic [3:0]  transfer_grant_out;
  logic [3:0]  service_request_out;
  logic [3:0]  mode_invalid_out;
  logic [3:0]  line;
  logic [3:0]  tc_ev;
  logic        temp_load;
  logic [7:0]  temp_data;
  logic        byte_high_out;
  cmd_fields_t cmd_out;
  mode_t [3:0] mode_out;
  logic [1:0]  cs;
  logic [3:0]  mm;
  logic [7:0]  d;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;
  // ignore rules: bit1 needs bit0, bit3 needs raw bit1, bit5 needs raw bit3
  logic [7:0]  cw [9] = '{8'hff, 8'h10, 8'h02, 8'h03, 8'h0b, 8'h09, 8'h2b, 8'h21, 8'h28};
  logic [7:0]  ce [9] = '{8'hff, 8'h10, 8'h00, 8'h03, 8'h0b, 8'h01, 8'h2b, 8'h01, 8'h20};

  always #12.5 clk_in = ~clk_in;

  dma_master_ctl u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .io_addr_in(io_addr_in),
    .io_wdata_in(io_wdata_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
    .io_rdata_out(io_rdata_out), .io_rvalid_out(io_rvalid_out),
    .transfer_request_line_in(line), .transfer_grant_out(transfer_grant_out),
    .tc_event_in(tc_ev), .grant_in(grant_in), .temp_load_in(temp_load),
    .temp_data_in(temp_data), .service_request_out(service_request_out), .cmd_out(cmd_out),
    .mode_out(mode_out), .mode_invalid_out(mode_invalid_out), .byte_high_out(byte_high_out));

  periph_model u_far (.clk_in(clk_in), .want_in(want), .active_low_in(active_low),
    .tc_fire_in(tc_fire), .temp_fire_in(temp_fire), .temp_val_in(temp_val),
    .line_out(line), .tc_out(tc_ev), .temp_load_out(temp_load), .temp_data_out(temp_data));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one access, strobe held across exactly one sampling edge
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_in);
    #2;
    io_addr_in = a;
    io_wdata_in = v;
    io_wr_in = w;
    io_rd_in = !w;
    @(posedge clk_in);
    #2;
    io_wr_in = 1'b0;
    io_rd_in = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk({7'h00, io_rvalid_out}, 8'h01);
    chk(io_rdata_out, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask

  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // a hang costs at most this many cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    settle(5);
    resetn_in = 1'b1;
    chk(cmd_out, 8'h00);
    chk(8'(transfer_grant_out), 8'h0f);
    want = 4'hf;
    settle(5);
    chk(8'(service_request_out), 8'h00);
    for (int c = 0; c < 4; c++) acc(1'b1, PORT_MASK, 8'(c));
    chk(8'(service_request_out), 8'h0f);
    rd(PORT_STATUS_CMD, 8'he0);
    acc(1'b1, PORT_MASK, 8'hfe);
    chk(8'(service_request_out), 8'h0b);
    acc(1'b1, PORT_MASK, 8'h02);
    tc_fire = 4'hf;
    settle(3);
    tc_fire = 4'h0;
    rd(PORT_STATUS_CMD, 8'hee);
    rd(PORT_STATUS_CMD, 8'he0);
    acc(1'b1, PORT_STATUS_CMD, 8'h04);
    chk(8'(service_request_out), 8'h00);
    acc(1'b1, PORT_STATUS_CMD, 8'h40);
    active_low = 1'b1;
    want = 4'h8;
    settle(5);
    chk(8'(service_request_out), 8'h08);
    rd(PORT_STATUS_CMD, 8'h80);
    acc(1'b1, PORT_STATUS_CMD, 8'h00);
    active_low = 1'b0;
    want = 4'h0;
    grant_in = 4'h2;
    settle(5);
    chk(8'(transfer_grant_out), 8'h0d);
    acc(1'b1, PORT_STATUS_CMD, 8'h80);
    settle(1);
    chk(8'(transfer_grant_out), 8'h02);
    grant_in = 4'h0;
    for (int i = 0; i < 9; i++) begin
      acc(1'b1, PORT_STATUS_CMD, cw[i]);
      chk(cmd_out, ce[i]);
    end
    acc(1'b1, 16'h00d3, 8'hff);
    rd(16'h00d1, 8'h00);
    rd(PORT_STATUS_CMD, 8'h00);
    chk(cmd_out, 8'h20);
    acc(1'b1, PORT_STATUS_CMD, 8'h00);
    acc(1'b1, PORT_MODE, 8'h82);
    acc(1'b1, PORT_REQUEST, 8'hfe);
    chk(8'(service_request_out), 8'h04);
    acc(1'b1, PORT_REQUEST, 8'h07);
    chk(8'(service_request_out), 8'h0c);
    acc(1'b1, PORT_MASK, 8'h07);
    chk(8'(service_request_out), 8'h04);
    acc(1'b1, PORT_REQUEST, 8'h02);
    chk(8'(service_request_out), 8'h00);
    for (int c = 0; c < 4; c++) begin
      for (int m = 0; m < 16; m++) begin
        cs = 2'(c);
        mm = 4'(m);
        d = {mm[3:2], cs[0], cs[1], mm[1:0], cs};
        acc(1'b1, PORT_MODE, d);
        chk(8'(mode_out[cs]), {2'h0, d[7:2]});
        chk(8'(mode_invalid_out[cs]), 8'(mm[1:0] == KIND_BAD && mm[3:2] != 2'h3));
      end
    end
    for (int c = 0; c < 4; c++) begin
      cs = 2'(c);
      chk(8'(mode_out[cs]), {4'h3, cs[0], cs[1], 2'h3});
    end
    acc(1'b1, PORT_PTR_CLEAR, 8'h5a);
    chk(8'(byte_high_out), 8'h00);
    acc(1'b1, 16'h00c4, 8'h34);
    chk(8'(byte_high_out), 8'h01);
    acc(1'b1, 16'h00c4, 8'h12);
    chk(8'(byte_high_out), 8'h00);
    acc(1'b0, 16'h00ce, 8'h00);
    chk(8'(byte_high_out), 8'h01);
    temp_val = 8'h5a;
    temp_fire = 1'b1;
    tc_fire = 4'h2;
    settle(3);
    temp_fire = 1'b0;
    tc_fire = 4'h0;
    rd(PORT_TEMP_DIS, 8'h5a);
    acc(1'b1, PORT_STATUS_CMD, 8'h10);
    acc(1'b1, PORT_TEMP_DIS, 8'h77);
    chk(cmd_out, 8'h00);
    chk(8'(byte_high_out), 8'h00);
    rd(PORT_TEMP_DIS, 8'h00);
    rd(PORT_STATUS_CMD, 8'h00);
    acc(1'b1, PORT_MASK, 8'h03);
    chk(8'(service_request_out), 8'h00);
    want = 4'hf;
    settle(5);
    chk(8'(service_request_out), 8'h08);
    stop_test();
  end
endmodule
